/* File: hdl/xcr_capability_operational_regs.sv */
/*
  Capability and operational register bank of a USB host controller:
  fixed capability words, command and status, ring and context pointers,
  configure word and eight per-port register sets, reached through a simple
  word access port into the first base address window.
  Assumes the requester is on clk and holds one request per cycle at most;
  the power-switch-absent bit comes from logic on the same clock.
*/
// What this block does
// - Extended capability pointer reads 0270h
// - Stream array limit field reads 1111
// - Secondary bandwidth domain bit reads zero
// - Forced stopped event bit reads zero
// - Secondary stream identifier bit reads zero
// - Latency tolerance messaging bit reads one
// - Light reset support bit reads one
// - Port indicator bit reads zero
// - Port power bit follows power-switch configuration
// - Context size bit reads one
// - Bandwidth negotiation bit reads zero
// - Wide address bit reads one
// - Capability parameter bits 11:10 read zero
// - Doorbell offset register reads 000005C0h
// - Runtime offset register reads 000004A0h
// - Operational base is base plus capability length
// - Eight port sets span 400h-47Fh
// - Command ring 18h-1Fh, context pointer 30h-37h
// - Command register resets to all zeros
// - Command bits: light reset, host error enable, interrupt enable, full reset, run
`timescale 1ns/1ps

module xcr_capability_operational_regs
  import xcr_pkg::*;
#(
  parameter int ADDR_W = 16,
  parameter logic [7:0] CAP_LENGTH = CAP_LENGTH_DEFAULT
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic memReq,
  input wire logic memWrite,
  input wire logic [ADDR_W-1:0] memAddr,
  input wire logic [31:0] memWdata,
  input wire logic [3:0] memByteEn,
  input wire logic powerSwitchAbsent,
  output logic rspValid,
  output logic [31:0] rspRdata,
  output logic runStop,
  output logic interruptEnable,
  output logic hostErrorEnable,
  output logic fullResetPulse,
  output logic lightResetPulse
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef logic [PORT_SETS-1:0][PORT_WORDS-1:0][31:0] xcr_port_t;

  typedef struct packed {
    logic rspValid;
    logic [31:0] rspRdata;
    logic [11:0] command;
    logic [15:0] notify;
    logic [63:0] cmdRing;
    logic [63:0] ctxPtr;
    logic [31:0] configure;
    xcr_port_t ports;
    logic fullPulse;
    logic lightPulse;
  } xcr_state_s;

  xcr_state_s state_reg;
  xcr_state_s state_next;

  function automatic logic [31:0] mergeBytes(
    input logic [31:0] oldWord,
    input logic [31:0] newWord,
    input logic [3:0] byteEn
  );
    logic [31:0] merged;
    merged = oldWord;
    for (int b = 0; b < 4; b++) begin
      if (byteEn[b]) begin
        merged[b*8 +: 8] = newWord[b*8 +: 8];
      end
    end
    return merged;
  endfunction

  // ---------------------------------------------------------------
  // Capability parameters word
  // ---------------------------------------------------------------
  logic [31:0] capParams;

  always_comb begin
    capParams = '0;
    capParams[CP_EXT_CAP_LSB +: 16] = EXT_CAP_POINTER_VALUE;
    capParams[CP_STREAM_LSB +: 4] = STREAM_ARRAY_LIMIT_VALUE;
    // Bits 11:10 stay at the zero given above
    capParams[CP_SECONDARY_BW_DOMAIN] = 1'b0;
    capParams[CP_FORCED_STOP_EVENT] = 1'b0;
    capParams[CP_SECONDARY_STREAM_ID_ABSENT] = 1'b0;
    capParams[CP_LATENCY_TOLERANCE_MSG] = 1'b1;
    capParams[CP_LIGHT_RESET] = 1'b1;
    capParams[CP_PORT_INDICATOR] = 1'b0;
    // Switches fitted means software may control port power
    capParams[CP_PORT_POWER_CONTROL] = ~powerSwitchAbsent;
    capParams[CP_CONTEXT_SIZE] = 1'b1;
    capParams[CP_BANDWIDTH_NEGOTIATION] = 1'b0;
    capParams[CP_WIDE_ADDRESS] = 1'b1;
  end

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  logic [ADDR_W-1:0] wordAddr;
  logic [ADDR_W-1:0] capBase;
  logic [ADDR_W-1:0] opOffs;
  logic inCap;
  logic inPort;
  logic [2:0] portIdx;
  logic [1:0] portWord;

  always_comb begin
    wordAddr = {memAddr[ADDR_W-1:2], 2'b00};
    capBase = ADDR_W'(CAP_LENGTH);
    inCap = wordAddr < capBase;
    opOffs = ADDR_W'(wordAddr - capBase);
    inPort = !inCap && opOffs >= ADDR_W'(OP_OFF_PORT_FIRST) && opOffs <= ADDR_W'(OP_OFF_PORT_LAST);
    portIdx = opOffs[6:4];
    portWord = opOffs[3:2];
  end

  // ---------------------------------------------------------------
  // Read mux and write effects
  // ---------------------------------------------------------------
  logic [31:0] readWord;
  logic [11:0] cmdWritten;
  logic [31:0] cmdMerged;
  logic [31:0] notifyMerged;

  always_comb begin
    readWord = '0;
    if (inCap) begin
      unique case (wordAddr)
        ADDR_W'(CAP_OFF_LENGTH): readWord = {24'h000000, CAP_LENGTH};
        ADDR_W'(CAP_OFF_PARAMS): readWord = capParams;
        ADDR_W'(CAP_OFF_DOORBELL): readWord = DOORBELL_OFFSET_VALUE;
        ADDR_W'(CAP_OFF_RUNTIME): readWord = RUNTIME_OFFSET_VALUE;
        default: readWord = '0;
      endcase
    end else if (inPort) begin
      readWord = state_reg.ports[portIdx][portWord];
    end else begin
      unique case (opOffs)
        ADDR_W'(OP_OFF_COMMAND): readWord = {20'h00000, state_reg.command};
        ADDR_W'(OP_OFF_STATUS): readWord = {31'h00000000, ~state_reg.command[CMD_RUN_STOP]};
        ADDR_W'(OP_OFF_PAGE_SIZE): readWord = PAGE_SIZE_VALUE;
        ADDR_W'(OP_OFF_NOTIFY): readWord = {16'h0000, state_reg.notify};
        ADDR_W'(OP_OFF_CMD_RING_LO): readWord = state_reg.cmdRing[31:0];
        ADDR_W'(OP_OFF_CMD_RING_HI): readWord = state_reg.cmdRing[63:32];
        ADDR_W'(OP_OFF_CTX_PTR_LO): readWord = state_reg.ctxPtr[31:0];
        ADDR_W'(OP_OFF_CTX_PTR_HI): readWord = state_reg.ctxPtr[63:32];
        ADDR_W'(OP_OFF_CONFIGURE): readWord = state_reg.configure;
        default: readWord = '0;
      endcase
    end
  end

  always_comb begin
    state_next = state_reg;
    state_next.rspValid = memReq;
    state_next.rspRdata = state_reg.rspRdata;
    state_next.fullPulse = 1'b0;
    state_next.lightPulse = 1'b0;
    // A function result cannot be part-selected, so merge into whole words first
    cmdMerged = mergeBytes({20'h00000, state_reg.command}, memWdata, memByteEn);
    notifyMerged = mergeBytes({16'h0000, state_reg.notify}, memWdata, memByteEn);
    cmdWritten = cmdMerged[11:0] & COMMAND_WRITE_MASK;
    if (memReq) begin
      state_next.rspRdata = memWrite ? 32'h00000000 : readWord;
    end
    // Capability words are ignored on write: no branch touches state for them
    if (memReq && memWrite && !inCap) begin
      if (inPort) begin
        state_next.ports[portIdx][portWord] = mergeBytes(state_reg.ports[portIdx][portWord], memWdata, memByteEn);
      end else begin
        unique case (opOffs)
          ADDR_W'(OP_OFF_COMMAND): begin
            // Reset request bits self-clear; they act as one-cycle strobes
            state_next.command = cmdWritten & ~(12'h001 << CMD_FULL_RESET) & ~(12'h001 << CMD_LIGHT_RESET);
            if (cmdWritten[CMD_FULL_RESET]) begin
              state_next.fullPulse = 1'b1;
              state_next.command = COMMAND_RESET;
              state_next.notify = '0;
              state_next.cmdRing = '0;
              state_next.ctxPtr = '0;
              state_next.configure = '0;
              state_next.ports = '0;
            end else if (cmdWritten[CMD_LIGHT_RESET]) begin
              // Light reset keeps pointers and port state, stops the controller
              state_next.lightPulse = 1'b1;
              state_next.command = COMMAND_RESET;
            end
          end
          ADDR_W'(OP_OFF_NOTIFY): begin
            state_next.notify = notifyMerged[15:0];
          end
          ADDR_W'(OP_OFF_CMD_RING_LO): begin
            state_next.cmdRing[31:0] = mergeBytes(state_reg.cmdRing[31:0], memWdata, memByteEn);
          end
          ADDR_W'(OP_OFF_CMD_RING_HI): begin
            state_next.cmdRing[63:32] = mergeBytes(state_reg.cmdRing[63:32], memWdata, memByteEn);
          end
          ADDR_W'(OP_OFF_CTX_PTR_LO): begin
            state_next.ctxPtr[31:0] = mergeBytes(state_reg.ctxPtr[31:0], memWdata, memByteEn);
          end
          ADDR_W'(OP_OFF_CTX_PTR_HI): begin
            state_next.ctxPtr[63:32] = mergeBytes(state_reg.ctxPtr[63:32], memWdata, memByteEn);
          end
          ADDR_W'(OP_OFF_CONFIGURE): begin
            state_next.configure = mergeBytes(state_reg.configure, memWdata, memByteEn);
          end
          default: begin
            state_next.configure = state_reg.configure;
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= '0;
      state_reg.command <= COMMAND_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign rspValid = state_reg.rspValid;
  assign rspRdata = state_reg.rspRdata;
  assign runStop = state_reg.command[CMD_RUN_STOP];
  assign interruptEnable = state_reg.command[CMD_INT_ENABLE];
  assign hostErrorEnable = state_reg.command[CMD_SYS_ERR_ENABLE];
  assign fullResetPulse = state_reg.fullPulse;
  assign lightResetPulse = state_reg.lightPulse;

endmodule

/* File: hdl/xcr_pkg.sv */
/*
  Constants for the capability and operational register bank: offsets,
  field positions, fixed field values and reset values.
  Assumes byte addresses relative to the start of the first base address window.
*/
package xcr_pkg;

  // ---------------------------------------------------------------
  // Capability register offsets
  // ---------------------------------------------------------------
  localparam logic [15:0] CAP_OFF_LENGTH = 16'h0000;
  localparam logic [15:0] CAP_OFF_PARAMS = 16'h0010;
  localparam logic [15:0] CAP_OFF_DOORBELL = 16'h0014;
  localparam logic [15:0] CAP_OFF_RUNTIME = 16'h0018;

  // ---------------------------------------------------------------
  // Operational register offsets, relative to the operational base
  // ---------------------------------------------------------------
  localparam logic [15:0] OP_OFF_COMMAND = 16'h0000;
  localparam logic [15:0] OP_OFF_STATUS = 16'h0004;
  localparam logic [15:0] OP_OFF_PAGE_SIZE = 16'h0008;
  localparam logic [15:0] OP_OFF_NOTIFY = 16'h0014;
  localparam logic [15:0] OP_OFF_CMD_RING_LO = 16'h0018;
  localparam logic [15:0] OP_OFF_CMD_RING_HI = 16'h001c;
  localparam logic [15:0] OP_OFF_CTX_PTR_LO = 16'h0030;
  localparam logic [15:0] OP_OFF_CTX_PTR_HI = 16'h0034;
  localparam logic [15:0] OP_OFF_CONFIGURE = 16'h0038;
  localparam logic [15:0] OP_OFF_PORT_FIRST = 16'h0400;
  localparam logic [15:0] OP_OFF_PORT_LAST = 16'h047f;

  // ---------------------------------------------------------------
  // Capability parameters word layout
  // ---------------------------------------------------------------
  localparam logic [15:0] EXT_CAP_POINTER_VALUE = 16'h0270;
  localparam logic [3:0] STREAM_ARRAY_LIMIT_VALUE = 4'hf;
  localparam int CP_EXT_CAP_LSB = 16;
  localparam int CP_STREAM_LSB = 12;
  localparam int CP_SECONDARY_BW_DOMAIN = 9;
  localparam int CP_FORCED_STOP_EVENT = 8;
  localparam int CP_SECONDARY_STREAM_ID_ABSENT = 7;
  localparam int CP_LATENCY_TOLERANCE_MSG = 6;
  localparam int CP_LIGHT_RESET = 5;
  localparam int CP_PORT_INDICATOR = 4;
  localparam int CP_PORT_POWER_CONTROL = 3;
  localparam int CP_CONTEXT_SIZE = 2;
  localparam int CP_BANDWIDTH_NEGOTIATION = 1;
  localparam int CP_WIDE_ADDRESS = 0;

  // ---------------------------------------------------------------
  // Fixed register values
  // ---------------------------------------------------------------
  localparam logic [31:0] DOORBELL_OFFSET_VALUE = 32'h000005c0;
  localparam logic [31:0] RUNTIME_OFFSET_VALUE = 32'h000004a0;
  localparam logic [31:0] PAGE_SIZE_VALUE = 32'h00000001;
  localparam logic [7:0] CAP_LENGTH_DEFAULT = 8'h20;

  // ---------------------------------------------------------------
  // USB command register layout
  // ---------------------------------------------------------------
  localparam logic [11:0] COMMAND_RESET = 12'h000;
  localparam logic [11:0] COMMAND_WRITE_MASK = 12'hf8f;
  localparam int CMD_RUN_STOP = 0;
  localparam int CMD_FULL_RESET = 1;
  localparam int CMD_INT_ENABLE = 2;
  localparam int CMD_SYS_ERR_ENABLE = 3;
  localparam int CMD_LIGHT_RESET = 7;
  localparam int STATUS_HALTED = 0;

  // ---------------------------------------------------------------
  // Per-port register sets
  // ---------------------------------------------------------------
  localparam int PORT_SETS = 8;
  localparam int PORT_WORDS = 4;

endpackage

/* File: test/xcr_capability_operational_regs_tb.sv */
/*
  Self-checking bench for the register bank, driving its word access port.
  Assumes a capability length of 40h so the operational base is moved.
*/
`timescale 1ns/1ps
module xcr_capability_operational_regs_tb
  import xcr_pkg::*;
;
  localparam logic [7:0] CL = 8'h40;
  localparam logic [15:0] OB = 16'h0040;
  logic clk = 0, arst_n = 0, memReq = 0, memWrite = 0, powerSwitchAbsent = 1;
  logic [15:0] memAddr = '0;
  logic [31:0] memWdata = '0, rd;
  logic [3:0] memByteEn = '0;
  logic rspValid, runStop, interruptEnable, hostErrorEnable, fullResetPulse, lightResetPulse, gotFull, gotLight;
  logic [31:0] rspRdata;
  logic [15:0] capOff [5] = '{16'h0000, 16'h0010, 16'h0014, 16'h0018, 16'h0020};
  logic [31:0] capExp [5] = '{{24'h0, CL}, 32'h0270f065, 32'h000005c0, 32'h000004a0, 32'h0};
  logic [15:0] opOff [5] = '{16'h0018, 16'h001c, 16'h0030, 16'h0034, 16'h0038};
  int n_errors = 0, tests_run = 0;
  always #4 clk = ~clk;
  xcr_capability_operational_regs #(.ADDR_W(16), .CAP_LENGTH(CL)) uut (.clk(clk), .arst_n(arst_n),
    .memReq(memReq), .memWrite(memWrite), .memAddr(memAddr), .memWdata(memWdata), .memByteEn(memByteEn),
    .powerSwitchAbsent(powerSwitchAbsent), .rspValid(rspValid), .rspRdata(rspRdata), .runStop(runStop),
    .interruptEnable(interruptEnable), .hostErrorEnable(hostErrorEnable), .fullResetPulse(fullResetPulse),
    .lightResetPulse(lightResetPulse));
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task complete_run;
    $display("errors %0d comparisons %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task check32(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task check1(input logic got, input logic exp);
    check32({31'h0, got}, {31'h0, exp});
  endtask
  // Entered just after an edge; an idle cycle follows so memReq never toggles twice in one step
  task access(input logic w, input logic [15:0] a, input logic [31:0] d);
    memReq = 1;
    memWrite = w;
    memAddr = a;
    memWdata = d;
    memByteEn = 4'hf;
    @(posedge clk);
    #1;
    memReq = 0;
    check1(rspValid, 1);
    rd = rspRdata;
    gotFull = fullResetPulse;
    gotLight = lightResetPulse;
    @(posedge clk);
    #1;
  endtask
  task rd_chk(input logic [15:0] a, input logic [31:0] exp);
    access(0, a, 32'h0);
    check32(rd, exp);
  endtask
  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    #1 arst_n = 1;
    rd_chk(OB, 32'h0);
    rd_chk(OB + 16'h4, 32'h1);
    for (int i = 0; i < 5; i++) rd_chk(capOff[i], capExp[i]);
    powerSwitchAbsent = 0;
    rd_chk(16'h0010, 32'h0270f06d);
    powerSwitchAbsent = 1;
    for (int i = 0; i < 5; i++) access(1, capOff[i], 32'hffffffff);
    check1(runStop, 0);
    for (int i = 1; i < 4; i++) rd_chk(capOff[i], capExp[i]);
    access(1, OB, 32'h0000000d);
    check1(runStop, 1);
    check1(interruptEnable & hostErrorEnable, 1);
    rd_chk(OB + 16'h4, 32'h0);
    for (int i = 0; i < 5; i++) access(1, OB + opOff[i], {16'ha5c3, opOff[i]});
    for (int i = 0; i < 5; i++) rd_chk(OB + opOff[i], {16'ha5c3, opOff[i]});
    for (int n = 0; n < 8; n++) access(1, 16'(OB + 16'h40c + n * 16), 32'h5a00 + n);
    for (int n = 0; n < 8; n++) rd_chk(16'(OB + 16'h40c + n * 16), 32'h5a00 + n);
    rd_chk(OB + 16'h480, 32'h0);
    access(1, OB, 32'h00000080);
    check1(gotLight & ~gotFull, 1);
    rd_chk(OB + 16'h18, 32'ha5c30018);
    access(1, OB, 32'h00000003);
    check1(gotFull & ~runStop, 1);
    rd_chk(OB + 16'h18, 32'h0);
    access(1, OB, 32'h00000001);
    arst_n = 0;
    @(posedge clk);
    #1;
    check1(runStop, 0);
    arst_n = 1;
    complete_run;
  end
  initial begin
    #20000;
    n_errors++;
    complete_run;
  end
endmodule

/* File: test/xcr_regs_assertions.sv */
/*
  Port checker for the capability and operational register bank.
  Assumes the bind below and at most one request per cycle.
*/
`timescale 1ns/1ps
module xcr_regs_assertions
  import xcr_pkg::*;
#(
  parameter int ADDR_W = 16,
  parameter logic [7:0] CAP_LENGTH = CAP_LENGTH_DEFAULT
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic memReq,
  input wire logic memWrite,
  input wire logic [ADDR_W-1:0] memAddr,
  input wire logic [31:0] memWdata,
  input wire logic [3:0] memByteEn,
  input wire logic powerSwitchAbsent,
  input wire logic rspValid,
  input wire logic [31:0] rspRdata,
  input wire logic runStop,
  input wire logic interruptEnable,
  input wire logic hostErrorEnable,
  input wire logic fullResetPulse,
  input wire logic lightResetPulse
);
  // ---------------------------------------------------------------
  // Request decode
  // ---------------------------------------------------------------
  wire logic rd = memReq && !memWrite;
  wire logic wr = memReq && memWrite;
  wire logic wrCmd = wr && memByteEn[0] && memAddr == ADDR_W'(CAP_LENGTH);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  chk_rsp_latency: assert property (memReq |=> rspValid) else $error("missing response");
  chk_rsp_quiet: assert property (!memReq |=> !rspValid) else $error("response without request");
  chk_params_fixed: assert property (rd && memAddr == ADDR_W'(CAP_OFF_PARAMS) |=>
    (rspRdata & 32'hfffffff7) == 32'h0270f065) else $error("capability word fixed fields wrong");
  chk_power_bit: assert property (rd && memAddr == ADDR_W'(CAP_OFF_PARAMS) |=>
    rspRdata[3] == !$past(powerSwitchAbsent)) else $error("port power bit wrong");
  chk_doorbell_word: assert property (rd && memAddr == ADDR_W'(CAP_OFF_DOORBELL) |=>
    rspRdata == 32'h000005c0) else $error("doorbell offset wrong");
  chk_runtime_word: assert property (rd && memAddr == ADDR_W'(CAP_OFF_RUNTIME) |=>
    rspRdata == 32'h000004a0) else $error("runtime offset wrong");
  chk_run_follows: assert property (wrCmd && !memWdata[1] && !memWdata[7] |=>
    runStop == $past(memWdata[0])) else $error("run bit not written");
  chk_full_pulse: assert property (wrCmd && memWdata[1] |=>
    fullResetPulse && !runStop ##1 !fullResetPulse) else $error("full reset pulse wrong");
  chk_light_pulse: assert property (wrCmd && memWdata[7] && !memWdata[1] |=>
    lightResetPulse && !fullResetPulse && !runStop) else $error("light reset pulse wrong");
  chk_cap_inert: assert property (wr && memAddr < ADDR_W'(CAP_LENGTH) |=>
    $stable(runStop) && !fullResetPulse && !lightResetPulse) else $error("capability write had effect");
  chk_reset_clear: assert property ($rose(arst_n) |->
    !runStop && !interruptEnable && !hostErrorEnable) else $error("command not clear after reset");
  chk_write_zero: assert property (wr |=> rspRdata == 32'h0) else $error("write returned data");
endmodule

bind xcr_capability_operational_regs xcr_regs_assertions #(.ADDR_W(ADDR_W), .CAP_LENGTH(CAP_LENGTH)) chk (
  .clk(clk), .arst_n(arst_n), .memReq(memReq), .memWrite(memWrite), .memAddr(memAddr),
  .memWdata(memWdata), .memByteEn(memByteEn), .powerSwitchAbsent(powerSwitchAbsent),
  .rspValid(rspValid), .rspRdata(rspRdata), .runStop(runStop), .interruptEnable(interruptEnable),
  .hostErrorEnable(hostErrorEnable), .fullResetPulse(fullResetPulse), .lightResetPulse(lightResetPulse));
